// ===== data_mem_addr.sv
// Purpose: internal data memory, bank and bit addressing, external moves, dual pointer
// Assumes: one request per cycle, results registered one cycle later, external load data two cycles later
// Notes:   special registers outside this block are reached over sfr_* ports
//
// Operation
// RULE_01 - internal memory is 256 bytes on one 8-bit address, direct or indirect
// RULE_02 - direct access to upper half goes to special registers only
// RULE_03 - indirect access to upper half goes to separate upper RAM
// RULE_04 - lowest 32 bytes are four banks of eight registers
// RULE_05 - two status word bits choose the active register bank
// RULE_06 - 16 bytes after banks are bit addressable, bit addresses 0x00-0x7F
// RULE_07 - lower 128 bytes give same result direct or indirect
// RULE_08 - external data space is a 16-bit range up to 64KB
// RULE_09 - external reads and writes only on external move load or store
// RULE_10 - register-indirect external move uses index reg zero or one, low byte
// RULE_11 - pointer external move drives full 16-bit selected pointer
// RULE_12 - external map: RAM, host bus, card control, peripheral control ranges
// RULE_13 - two 16-bit pointers, select bit 0 primary, 1 secondary
// RULE_14 - every pointer instruction acts on the selected pointer
// RULE_15 - with flash write enable, pointer store writes accumulator to flash
// RULE_16 - unpopulated external addresses: writes dropped, reads return fixed value
`timescale 1ns/1ps
module data_mem_addr
  import mem_addr_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        dir_rd_in,
  input  wire logic        dir_wr_in,
  input  wire logic        ind_rd_in,
  input  wire logic        ind_wr_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic        bank_reg_in,
  input  wire logic [2:0]  bank_idx_in,
  input  wire logic        bit_rd_in,
  input  wire logic        bit_wr_in,
  input  wire logic [7:0]  bit_addr_in,
  input  wire logic        bit_val_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        xmove_rd_in,
  input  wire logic        xmove_wr_in,
  input  wire logic        xmove_ptr_in,
  input  wire logic        xmove_ri_sel_in,
  input  wire logic        ptr_inc_in,
  input  wire logic        ptr_load_in,
  input  wire logic [15:0] ptr_value_in,
  input  wire logic [7:0]  xdata_in,
  input  wire logic [7:0]  sfr_rdata_in,
  output logic [7:0]       rdata_out,
  output logic             rbit_out,
  output logic             rvalid_out,
  output logic [15:0]      xaddr_out,
  output logic [7:0]       xwdata_out,
  output logic             extram_wr_out,
  output logic             extram_rd_out,
  output logic [2:0]       xregion_out,
  output logic             flash_wr_out,
  output logic [7:0]       sfr_addr_out,
  output logic [7:0]       sfr_wdata_out,
  output logic             sfr_wr_out,
  output logic [15:0]      ptr_out,
  output logic [1:0]       bank_out,
  output logic             ptr_sel_out
);
  logic [7:0]  lower_ram [0:127];
  logic [7:0]  upper_ram [0:127];
  logic [7:0]  processor_status_word, next_status;
  logic [7:0]  pointer_select_reg, next_psel;
  logic        flash_program_write_enable, next_pwe;
  logic [15:0] primary_data_pointer, next_dp0;
  logic [15:0] secondary_data_pointer, next_dp1;
  logic [7:0]  rdata, next_rdata;
  logic        rbit, next_rbit, rvalid, next_rvalid;
  logic [15:0] xaddr, next_xaddr;
  logic [7:0]  xwdata, next_xwdata;
  logic        extram_wr, next_extram_wr, extram_rd, next_extram_rd, flash_wr, next_flash_wr;
  logic [2:0]  xregion, next_xregion;
  logic [7:0]  sfr_addr, next_sfr_addr, sfr_wdata, next_sfr_wdata;
  logic        sfr_wr, next_sfr_wr;
  logic        pend_xrd, next_pend_xrd, pend_xok, next_pend_xok;

  logic [1:0]  bank;
  logic        ptr_sel;
  logic [15:0] cur_ptr;
  logic [7:0]  eff_addr;
  logic        ram_wr;
  logic [6:0]  ram_idx;
  logic        ram_upper;
  logic [7:0]  ram_wdata;
  logic [7:0]  ri_addr;
  logic [7:0]  bit_byte;
  logic [7:0]  bit_word;
  ext_bus_if   xbus();

  assign bank     = processor_status_word[STATUS_BANK_HI:STATUS_BANK_LO]; // [RULE_05]
  assign ptr_sel  = pointer_select_reg[PSEL_BIT]; // [RULE_13]
  assign cur_ptr  = ptr_sel ? secondary_data_pointer : primary_data_pointer; // [RULE_14]
  // bank registers sit at bank*8 + index within the low 32 bytes
  assign eff_addr = bank_reg_in ? {3'h0, bank, bank_idx_in} : addr_in; // [RULE_04]
  assign ri_addr  = lower_ram[{2'h0, bank, 2'h0, xmove_ri_sel_in}]; // [RULE_10]
  // bit address 0x00-0x7F selects byte 0x20 + addr/8, bit addr%8
  assign bit_byte = BITAREA_BASE + {4'h0, bit_addr_in[6:3]}; // [RULE_06]
  assign bit_word = lower_ram[bit_byte[6:0]];

  assign xbus.addr      = xmove_ptr_in ? cur_ptr : {8'h00, ri_addr}; // [RULE_11] [RULE_08]
  assign xbus.rd        = xmove_rd_in;
  assign xbus.wr        = xmove_wr_in;
  assign xbus.flash_sel = xmove_ptr_in && flash_program_write_enable;

  ext_decode u_decode (
    .bus (xbus)
  );

  always_comb begin
    ram_wr    = 1'b0;
    ram_upper = eff_addr[7];
    ram_idx   = eff_addr[6:0];
    ram_wdata = wdata_in;
    if (bit_wr_in && !bit_addr_in[7]) begin
      ram_wr    = 1'b1;
      ram_upper = 1'b0;
      ram_idx   = bit_byte[6:0];
      ram_wdata = bit_word;
      ram_wdata[bit_addr_in[2:0]] = bit_val_in; // [RULE_06]
    end else if (ind_wr_in) begin
      ram_wr = 1'b1; // [RULE_03] [RULE_07]
    end else if (dir_wr_in && !eff_addr[7]) begin
      ram_wr = 1'b1; // [RULE_07]
    end
  end

  always_ff @(posedge clk_in) begin
    if (ram_wr && ram_upper) begin
      upper_ram[ram_idx] <= ram_wdata; // [RULE_01]
    end
    if (ram_wr && !ram_upper) begin
      lower_ram[ram_idx] <= ram_wdata;
    end
  end

  always_comb begin
    next_status    = processor_status_word;
    next_psel      = pointer_select_reg;
    next_pwe       = flash_program_write_enable;
    next_dp0       = primary_data_pointer;
    next_dp1       = secondary_data_pointer;
    next_rdata     = rdata;
    next_rbit      = rbit;
    next_rvalid    = 1'b0;
    next_sfr_addr  = sfr_addr;
    next_sfr_wdata = sfr_wdata;
    next_sfr_wr    = 1'b0;
    next_xaddr     = xaddr;
    next_xwdata    = xwdata;
    next_extram_wr = 1'b0;
    next_extram_rd = 1'b0;
    next_flash_wr  = 1'b0;
    next_xregion   = xregion;
    next_pend_xrd  = 1'b0;
    next_pend_xok  = 1'b0;
    if (pend_xrd) begin
      next_rdata  = pend_xok ? xdata_in : UNMAPPED_DATA; // [RULE_16]
      next_rvalid = 1'b1;
    end
    if (dir_wr_in && eff_addr[7]) begin
      // direct upper-half write never touches upper RAM
      next_sfr_addr  = eff_addr; // [RULE_02]
      next_sfr_wdata = wdata_in;
      next_sfr_wr    = 1'b1;
      unique case (eff_addr)
        SFR_STATUS: next_status = wdata_in;
        SFR_PSEL:  next_psel = wdata_in;
        SFR_FLCTL: next_pwe  = wdata_in[PWE_BIT];
        SFR_DPL0:  next_dp0[7:0]  = wdata_in;
        SFR_DPH0:  next_dp0[15:8] = wdata_in;
        SFR_DPL1:  next_dp1[7:0]  = wdata_in;
        SFR_DPH1:  next_dp1[15:8] = wdata_in;
        default:   next_status = processor_status_word;
      endcase
    end
    if (dir_rd_in) begin
      next_rvalid = 1'b1;
      if (!eff_addr[7]) begin
        next_rdata = lower_ram[eff_addr[6:0]]; // [RULE_07]
      end else begin
        unique case (eff_addr)
          SFR_STATUS: next_rdata = processor_status_word; // [RULE_02]
          SFR_PSEL:  next_rdata = pointer_select_reg;
          SFR_FLCTL: next_rdata = {7'h00, flash_program_write_enable};
          SFR_DPL0:  next_rdata = primary_data_pointer[7:0];
          SFR_DPH0:  next_rdata = primary_data_pointer[15:8];
          SFR_DPL1:  next_rdata = secondary_data_pointer[7:0];
          SFR_DPH1:  next_rdata = secondary_data_pointer[15:8];
          default:   next_rdata = sfr_rdata_in;
        endcase
      end
    end else if (ind_rd_in) begin
      next_rvalid = 1'b1;
      next_rdata  = eff_addr[7] ? upper_ram[eff_addr[6:0]] : lower_ram[eff_addr[6:0]]; // [RULE_03]
    end else if (bit_rd_in) begin
      next_rvalid = 1'b1;
      next_rbit   = bit_addr_in[7] ? sfr_rdata_in[bit_addr_in[2:0]]
                                   : bit_word[bit_addr_in[2:0]]; // [RULE_06]
    end
    if (ptr_load_in || ptr_inc_in) begin
      if (ptr_sel) begin
        next_dp1 = ptr_load_in ? ptr_value_in : secondary_data_pointer + 16'h0001; // [RULE_14]
      end else begin
        next_dp0 = ptr_load_in ? ptr_value_in : primary_data_pointer + 16'h0001;
      end
    end
    if (xmove_wr_in || xmove_rd_in) begin
      next_xaddr   = xbus.addr;
      next_xwdata  = wdata_in;
      next_xregion = xbus.region;
      next_extram_wr = xbus.wr_ok; // [RULE_09] [RULE_12] [RULE_16]
      next_extram_rd = xbus.rd_ok;
      next_pend_xrd = xmove_rd_in;
      next_pend_xok = xbus.rd_ok;
      if (xmove_wr_in && xbus.flash_sel) begin
        next_flash_wr = 1'b1; // [RULE_15]
        next_pwe      = 1'b0; // enable clears after each flash byte
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      processor_status_word      <= STATUS_RESET;
      pointer_select_reg         <= PSEL_RESET;
      flash_program_write_enable <= 1'b0;
      primary_data_pointer       <= POINTER_RESET;
      secondary_data_pointer     <= POINTER_RESET;
      rdata     <= 8'h00;
      rbit      <= 1'b0;
      rvalid    <= 1'b0;
      xaddr     <= 16'h0000;
      xwdata    <= 8'h00;
      extram_wr <= 1'b0;
      extram_rd <= 1'b0;
      flash_wr  <= 1'b0;
      xregion   <= REGION_NONE;
      sfr_addr  <= 8'h00;
      sfr_wdata <= 8'h00;
      sfr_wr    <= 1'b0;
      pend_xrd  <= 1'b0;
      pend_xok  <= 1'b0;
    end else begin
      processor_status_word      <= next_status;
      pointer_select_reg         <= next_psel;
      flash_program_write_enable <= next_pwe;
      primary_data_pointer       <= next_dp0;
      secondary_data_pointer     <= next_dp1;
      rdata     <= next_rdata;
      rbit      <= next_rbit;
      rvalid    <= next_rvalid;
      xaddr     <= next_xaddr;
      xwdata    <= next_xwdata;
      extram_wr <= next_extram_wr;
      extram_rd <= next_extram_rd;
      flash_wr  <= next_flash_wr;
      xregion   <= next_xregion;
      sfr_addr  <= next_sfr_addr;
      sfr_wdata <= next_sfr_wdata;
      sfr_wr    <= next_sfr_wr;
      pend_xrd  <= next_pend_xrd;
      pend_xok  <= next_pend_xok;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ptr_out     <= POINTER_RESET;
      bank_out    <= 2'h0;
      ptr_sel_out <= 1'b0;
    end else begin
      // follow the select being written now, else the output lags a select change
      ptr_out     <= next_psel[PSEL_BIT] ? next_dp1 : next_dp0; // [RULE_13]
      bank_out    <= next_status[STATUS_BANK_HI:STATUS_BANK_LO];
      ptr_sel_out <= next_psel[PSEL_BIT];
    end
  end

  assign rdata_out     = rdata;
  assign rbit_out      = rbit;
  assign rvalid_out    = rvalid;
  assign xaddr_out     = xaddr;
  assign xwdata_out    = xwdata;
  assign extram_wr_out = extram_wr;
  assign extram_rd_out = extram_rd;
  assign xregion_out   = xregion;
  assign flash_wr_out  = flash_wr;
  assign sfr_addr_out  = sfr_addr;
  assign sfr_wdata_out = sfr_wdata;
  assign sfr_wr_out    = sfr_wr;
endmodule

// ===== mem_addr_pkg.sv
// Purpose: shared constants for the core data memory addressing block
// Assumes: 8-bit core, 16-bit external data space
// Notes:   special register offsets are chosen locally for the unit's own registers
package mem_addr_pkg;
  localparam int          IDATA_DEPTH     = 256;
  localparam logic [7:0]  UPPER_BASE      = 8'h80;
  localparam logic [7:0]  BITAREA_BASE    = 8'h20;
  localparam logic [7:0]  BITADDR_MAX     = 8'h7F;
  localparam int          BANK_SHIFT      = 3;
  localparam int          STATUS_BANK_LO  = 3;
  localparam int          STATUS_BANK_HI  = 4;
  localparam int          PSEL_BIT        = 0;
  localparam int          PWE_BIT         = 0;
  // special register addresses served by this block
  localparam logic [7:0]  SFR_DPL0        = 8'h82;
  localparam logic [7:0]  SFR_DPH0        = 8'h83;
  localparam logic [7:0]  SFR_DPL1        = 8'h84;
  localparam logic [7:0]  SFR_DPH1        = 8'h85;
  localparam logic [7:0]  SFR_PSEL        = 8'h86;
  localparam logic [7:0]  SFR_STATUS      = 8'hD0;
  localparam logic [7:0]  SFR_FLCTL       = 8'hB2;
  localparam logic [7:0]  PSEL_RESET      = 8'h00;
  localparam logic [7:0]  STATUS_RESET    = 8'h00;
  localparam logic [15:0] POINTER_RESET   = 16'h0000;
  // external data map
  localparam logic [15:0] EXTRAM_LAST     = 16'h07FF;
  localparam logic [15:0] HOSTBUS_FIRST   = 16'hFC00;
  localparam logic [15:0] HOSTBUS_LAST    = 16'hFDFF;
  localparam logic [15:0] CARD_FIRST      = 16'hFE00;
  localparam logic [15:0] CARD_LAST       = 16'hFF7F;
  localparam logic [15:0] PERIPH_FIRST    = 16'hFF80;
  localparam logic [7:0]  UNMAPPED_DATA   = 8'hFF;

  typedef enum logic [2:0] {
    REGION_NONE, REGION_EXTRAM, REGION_HOSTBUS, REGION_CARD, REGION_PERIPH
  } ext_region_t;

  typedef enum logic [2:0] {
    OP_NONE, OP_DIR_RD, OP_DIR_WR, OP_IND_RD, OP_IND_WR,
    OP_XRD_RI, OP_XWR_RI
  } op_t;
endpackage

// ===== ext_bus_if.sv
// Purpose: carrier between the top and the external map decoder
// Assumes: one decode per cycle
// Notes:   none
`timescale 1ns/1ps
interface ext_bus_if;
  import mem_addr_pkg::*;
  logic [15:0] addr;
  logic        rd;
  logic        wr;
  logic        flash_sel;
  ext_region_t region;
  logic        rd_ok;
  logic        wr_ok;
  modport top (output addr, output rd, output wr, output flash_sel,
               input region, input rd_ok, input wr_ok);
  modport dec (input addr, input rd, input wr, input flash_sel,
               output region, output rd_ok, output wr_ok);
endinterface

// ===== ext_decode.sv
// Purpose: decodes an external data address into its populated region
// Assumes: combinational, same clock as the caller
// Notes:   unpopulated range gives no strobe at all
`timescale 1ns/1ps
module ext_decode
  import mem_addr_pkg::*;
(
  ext_bus_if.dec bus
);
  ext_region_t region;

  always_comb begin
    if (bus.addr <= EXTRAM_LAST) begin
      region = REGION_EXTRAM; // [RULE_12]
    end else if (bus.addr >= HOSTBUS_FIRST && bus.addr <= HOSTBUS_LAST) begin
      region = REGION_HOSTBUS;
    end else if (bus.addr >= CARD_FIRST && bus.addr <= CARD_LAST) begin
      region = REGION_CARD;
    end else if (bus.addr >= PERIPH_FIRST) begin
      region = REGION_PERIPH;
    end else begin
      region = REGION_NONE;
    end
  end

  assign bus.region = region;
  // a flash-directed store raises no external write strobe
  assign bus.wr_ok  = bus.wr && !bus.flash_sel && (region != REGION_NONE);
  assign bus.rd_ok  = bus.rd && (region != REGION_NONE);
endmodule

// ===== data_mem_addr_assertions.sv
// Purpose: port-level checks of the data memory addressing block
// Assumes: single clock, async active-high reset
// Notes:   pointer address check skips cycles that load or step a pointer
`timescale 1ns/1ps
module data_mem_addr_assertions (
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic        dir_rd_in,
  input wire logic        dir_wr_in,
  input wire logic        ind_wr_in,
  input wire logic [7:0]  addr_in,
  input wire logic        bank_reg_in,
  input wire logic        xmove_rd_in,
  input wire logic        xmove_wr_in,
  input wire logic        xmove_ptr_in,
  input wire logic        ptr_inc_in,
  input wire logic        ptr_load_in,
  input wire logic        rvalid_out,
  input wire logic [15:0] xaddr_out,
  input wire logic        extram_wr_out,
  input wire logic        extram_rd_out,
  input wire logic [2:0]  xregion_out,
  input wire logic        flash_wr_out,
  input wire logic [7:0]  sfr_addr_out,
  input wire logic        sfr_wr_out,
  input wire logic [15:0] ptr_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  function automatic logic [2:0] exp_region(input logic [15:0] a);
    if (a <= 16'h07FF) return 3'h1;
    if (a < 16'hFC00) return 3'h0;
    if (a < 16'hFE00) return 3'h2;
    if (a < 16'hFF80) return 3'h3;
    return 3'h4;
  endfunction
  // load is two steps: strobe out, then data back
  sequence s_load_resp;
    ##1 rvalid_out;
  endsequence
  a_read_answers: assert property (dir_rd_in |=> rvalid_out)
    else $error("direct read gave no valid");
  a_dir_upper_sfr: assert property (dir_wr_in && !bank_reg_in && addr_in[7]
    |=> sfr_wr_out && sfr_addr_out == $past(addr_in)) else $error("upper write missed sfr");
  a_ind_not_sfr: assert property (ind_wr_in && !dir_wr_in |=> !sfr_wr_out)
    else $error("indirect write reached sfr");
  a_no_stray_ext: assert property (!xmove_wr_in && !xmove_rd_in
    |=> !extram_wr_out && !flash_wr_out && !extram_rd_out) else $error("stray external strobe");
  a_ri_low_page: assert property (xmove_wr_in && !xmove_ptr_in
    |=> extram_wr_out && xaddr_out[15:8] == 8'h00) else $error("index store off first page");
  a_ptr_store_addr: assert property (xmove_wr_in && xmove_ptr_in && !ptr_inc_in
    && !ptr_load_in |=> xaddr_out == $past(ptr_out)) else $error("pointer address wrong");
  a_region_map: assert property (extram_wr_out || extram_rd_out
    |-> xregion_out == exp_region(xaddr_out)) else $error("external region wrong");
  a_ptr_step: assert property (ptr_inc_in && !ptr_load_in && !dir_wr_in
    |=> ptr_out == $past(ptr_out) + 16'h0001) else $error("pointer step wrong");
  a_load_seq: assert property (xmove_rd_in |=> s_load_resp)
    else $error("external load gave no valid");
endmodule
bind data_mem_addr data_mem_addr_assertions u_chk (.clk_in, .reset_in, .dir_rd_in,
  .dir_wr_in, .ind_wr_in, .addr_in, .bank_reg_in, .xmove_rd_in, .xmove_wr_in, .xmove_ptr_in,
  .ptr_inc_in, .ptr_load_in, .rvalid_out, .xaddr_out, .extram_wr_out, .extram_rd_out,
  .xregion_out, .flash_wr_out, .sfr_addr_out, .sfr_wr_out, .ptr_out);

// ===== ext_mem_model.sv
// Purpose: far-side model of external data space and foreign special registers
// Assumes: load data answered in the cycle the read strobe stands
// Notes:   idle read lines toggle each cycle so stale data cannot pass
`timescale 1ns/1ps
module ext_mem_model (
  input  wire logic        clk_in,
  input  wire logic [15:0] xaddr_in,
  input  wire logic [7:0]  xwdata_in,
  input  wire logic        xwr_in,
  input  wire logic        xrd_in,
  input  wire logic        sfr_rd_in,
  input  wire logic [7:0]  sfr_raddr_in,
  input  wire logic [7:0]  sfr_waddr_in,
  input  wire logic [7:0]  sfr_wdata_in,
  input  wire logic        sfr_wr_in,
  output logic      [7:0]  xdata_out,
  output logic      [7:0]  sfr_rdata_out
);
  logic [7:0] xmem [0:65535]; // whole 16-bit space
  logic [7:0] sfr_mem [0:255];
  logic       tog = 1'b0;
  always @(posedge clk_in) begin
    tog <= ~tog;
    if (xwr_in) xmem[xaddr_in] <= xwdata_in;
    if (sfr_wr_in) sfr_mem[sfr_waddr_in] <= sfr_wdata_in;
  end
  assign xdata_out = xrd_in ? xmem[xaddr_in] : {8{tog}};
  assign sfr_rdata_out = sfr_rd_in ? sfr_mem[sfr_raddr_in] : {8{tog}};
endmodule

// ===== tb_top.sv
// Purpose: self-checking bench for the data memory addressing block
// Assumes: 50 MHz clock, inputs driven on the falling edge
// Notes:   one idle cycle between requests, two after an external load, keeps the driver simple
`timescale 1ns/1ps
module tb_top;
  typedef struct {int k; logic [15:0] a; logic [7:0] d;} row_t;
  logic clk_in, reset_in, dir_rd_in, dir_wr_in, ind_rd_in, ind_wr_in, bank_reg_in;
  logic bit_rd_in, bit_wr_in, bit_val_in, xmove_rd_in, xmove_wr_in, xmove_ptr_in;
  logic xmove_ri_sel_in, ptr_inc_in, ptr_load_in, rbit_out, rvalid_out, extram_wr_out;
  logic extram_rd_out, flash_wr_out, sfr_wr_out, ptr_sel_out;
  logic [2:0]  bank_idx_in, xregion_out;
  logic [1:0]  bank_out;
  logic [7:0]  addr_in, bit_addr_in, wdata_in, xdata_in, sfr_rdata_in, rdata_out;
  logic [7:0]  xwdata_out, sfr_addr_out, sfr_wdata_out;
  logic [15:0] ptr_value_in, xaddr_out, ptr_out;
  int          fails = 0;
  int          num_checks = 0;
  // k: 0 dir rd, 1 dir wr, 2 ind rd, 3 ind wr
  row_t rows [11] = '{'{1, 16'h0030, 8'hA5}, '{2, 16'h0030, 8'hA5}, '{3, 16'h007F, 8'h3C},
    '{0, 16'h007F, 8'h3C}, '{3, 16'h0090, 8'h11}, '{1, 16'h0090, 8'h22},
    '{2, 16'h0090, 8'h11}, '{0, 16'h0090, 8'h22}, '{3, 16'h00FF, 8'h77},
    '{2, 16'h00FF, 8'h77}, '{2, 16'h0030, 8'hA5}};
  logic [15:0] map_a [9] = '{16'h07FF, 16'hFC00, 16'hFDFF, 16'hFE00, 16'hFF7F, 16'hFF80,
    16'hFFFF, 16'hFBFF, 16'h0800};
  logic [2:0]  map_r [9] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h0, 3'h0};

  data_mem_addr u_data_mem_addr (.*);
  ext_mem_model u_ext_mem_model (.clk_in(clk_in), .xaddr_in(xaddr_out),
    .xwdata_in(xwdata_out), .xwr_in(extram_wr_out), .xrd_in(extram_rd_out),
    .sfr_rd_in(dir_rd_in || bit_rd_in),
    .sfr_raddr_in(bit_rd_in ? {bit_addr_in[7:3], 3'h0} : addr_in),
    .sfr_waddr_in(sfr_addr_out),
    .sfr_wdata_in(sfr_wdata_out), .sfr_wr_in(sfr_wr_out), .xdata_out(xdata_in),
    .sfr_rdata_out(sfr_rdata_in));

  always #10 clk_in = ~clk_in;

  task automatic clr();
    {dir_rd_in, dir_wr_in, ind_rd_in, ind_wr_in, bank_reg_in, bit_rd_in, bit_wr_in} = '0;
    {xmove_rd_in, xmove_wr_in, xmove_ptr_in, xmove_ri_sel_in, ptr_inc_in, ptr_load_in} = '0;
  endtask

  // one request, then released; external loads wait one more cycle for data
  task automatic go(input int k, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_in = a[7:0];
    bank_idx_in = a[2:0];
    bit_addr_in = a[7:0];
    bit_val_in = d[0];
    wdata_in = d;
    ptr_value_in = a;
    xmove_ri_sel_in = a[0];
    case (k)
      0: dir_rd_in = 1'b1;
      1: dir_wr_in = 1'b1;
      2: ind_rd_in = 1'b1;
      3: ind_wr_in = 1'b1;
      5: {bank_reg_in, dir_wr_in} = 2'b11;
      6: bit_rd_in = 1'b1;
      7: bit_wr_in = 1'b1;
      8: {xmove_ptr_in, xmove_rd_in} = 2'b11;
      9: {xmove_ptr_in, xmove_wr_in} = 2'b11;
      10: xmove_rd_in = 1'b1;
      11: xmove_wr_in = 1'b1;
      12: ptr_load_in = 1'b1;
      default: ptr_inc_in = 1'b1;
    endcase
    @(negedge clk_in);
    clr();
    if (k == 8 || k == 10) @(negedge clk_in);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (fails == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #100_000;
    fails++;
    end_sim();
  end

  initial begin
    clk_in = 1'b0;
    reset_in = 1'b1;
    clr();
    {bank_idx_in, addr_in, bit_addr_in, bit_val_in, wdata_in, ptr_value_in} = '0;
    repeat (16) @(negedge clk_in);
    reset_in = 1'b0;
    chk(ptr_out, 16'h0000);
    chk(16'({bank_out, ptr_sel_out, rvalid_out}), 16'h0000);
    foreach (rows[i]) begin
      go(rows[i].k, rows[i].a, rows[i].d);
      if (rows[i].k inside {0, 2})
        chk(16'({rvalid_out, rdata_out}), 16'({1'b1, rows[i].d}));
    end
    // walk all four banks, each through its own register seven
    for (int b = 0; b < 4; b++) begin
      go(1, 16'h00D0, 8'(b << 3));
      chk(16'(bank_out), 16'(b));
      go(5, 16'h0007, 8'(8'h40 + b));
      go(2, 16'(8 * b + 7), 8'h00);
      chk(16'(rdata_out), 16'(8'h40 + b));
    end
    go(5, 16'h0000, 8'h44);
    go(11, 16'h0000, 8'h66);
    chk(xaddr_out, 16'h0044);
    go(10, 16'h0000, 8'h00);
    chk(16'(rdata_out), 16'h0066);
    go(1, 16'h0021, 8'h00);
    go(7, 16'h000A, 8'h01);
    go(2, 16'h0021, 8'h00);
    chk(16'(rdata_out), 16'h0004);
    go(1, 16'h002F, 8'h80);
    go(6, 16'h007F, 8'h00);
    chk(16'(rbit_out), 16'h0001);
    go(6, 16'h0094, 8'h00);
    chk(16'(rbit_out), 16'h0000);
    go(12, 16'hFC10, 8'h00);
    go(1, 16'h0086, 8'h01);
    chk(16'(ptr_sel_out), 16'h0001);
    go(12, 16'h0005, 8'h00);
    go(13, 16'h0000, 8'h00);
    chk(ptr_out, 16'h0006);
    go(9, 16'h0000, 8'h9A);
    chk(xaddr_out, 16'h0006);
    go(8, 16'h0000, 8'h00);
    chk(16'(rdata_out), 16'h009A);
    go(1, 16'h0086, 8'h00);
    chk(ptr_out, 16'hFC10);
    go(0, 16'h0082, 8'h00);
    chk(16'(rdata_out), 16'h0010);
    // flash enable steers one pointer store, then falls back to the bus
    go(1, 16'h00B2, 8'h01);
    go(9, 16'h0000, 8'h01);
    chk(16'({flash_wr_out, extram_wr_out}), 16'h0002);
    chk(16'(xwdata_out), 16'h0001);
    go(9, 16'h0000, 8'h02);
    chk(16'({flash_wr_out, extram_wr_out}), 16'h0001);
    foreach (map_a[i]) begin
      go(12, map_a[i], 8'h00);
      go(9, 16'h0000, 8'h3C);
      chk(16'(xregion_out), 16'(map_r[i]));
      chk(16'(extram_wr_out), 16'(map_r[i] != 3'h0));
    end
    go(8, 16'h0000, 8'h00);
    chk(16'(rdata_out), 16'h00FF);
    reset_in = 1'b1;
    repeat (2) @(negedge clk_in);
    reset_in = 1'b0;
    chk(ptr_out, 16'h0000);
    chk(16'({bank_out, ptr_sel_out, rvalid_out}), 16'h0000);
    end_sim();
  end
endmodule
